//--- logic/fpe_pkg.sv
// Purpose: shared constants for the flash program/erase sequencer
// Assumes: 32-bit classic wishbone slave, word-aligned registers
// Notes:   all offsets, field positions and counts live here
package fpe_pkg;

    // ========================================================
    // register byte offsets
    localparam logic [3:0] FPE_OFF_CTRL = 4'h0;
    localparam logic [3:0] FPE_OFF_STAT = 4'h4;
    localparam logic [3:0] FPE_OFF_MASK = 4'h8;

    // ========================================================
    // control register field positions
    localparam int FPE_BIT_START  = 15;
    localparam int FPE_BIT_PERMIT = 14;
    localparam int FPE_BIT_ERR    = 13;
    localparam int FPE_BIT_ERASE  = 6;
    localparam int FPE_OP_LSB     = 0;

    // control register value after power-on
    localparam logic [15:0] FPE_CTRL_RST = 16'h0000;

    // ========================================================
    // operation codes
    localparam logic [3:0] FPE_OP_BULK   = 4'hF;
    localparam logic [3:0] FPE_OP_GENSEG = 4'hD;
    localparam logic [3:0] FPE_OP_SECSEG = 4'hC;
    localparam logic [3:0] FPE_OP_WORD   = 4'h3;
    localparam logic [3:0] FPE_OP_PAGE   = 4'h2;
    localparam logic [3:0] FPE_OP_ROW    = 4'h1;
    localparam logic [3:0] FPE_OP_CFG    = 4'h0;

    // ========================================================
    // operation kinds issued to the array
    typedef enum logic [2:0] {
        FPE_K_NONE   = 3'h0,
        FPE_K_BULK   = 3'h1,
        FPE_K_GENSEG = 3'h2,
        FPE_K_SECSEG = 3'h3,
        FPE_K_PAGE   = 3'h4,
        FPE_K_WORD   = 3'h5,
        FPE_K_ROW    = 3'h6,
        FPE_K_CFG    = 3'h7
    } fpe_kind_t;

    // ========================================================
    // timing: internal timeout for array completion
    localparam int FPE_CLK_MHZ     = 250;
    localparam int FPE_TMO_US      = 100;
    localparam int FPE_TMO_CYC     = FPE_TMO_US * FPE_CLK_MHZ;
    localparam int FPE_NOP_CYC     = 4;

    // status / mask bits
    localparam int FPE_IRQ_DONE = 0;
    localparam int FPE_IRQ_ERR  = 1;

endpackage

//--- logic/fpe_timer.sv
// Purpose: down-counter that times one flash operation
// Assumes: load wins over counting
// Notes:   expired pulses once when the count reaches zero
`timescale 1ns/1ps
`default_nettype none
module fpe_timer #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    input  wire logic         stop_i,
    output logic              expired_o
);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         run_q;
    logic         run_d;
    logic         exp_q;
    logic         exp_d;

    // ========================================================
    // next count
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        exp_d = 1'b0;
        if (load_i) begin
            cnt_d = count_i;
            run_d = 1'b1;
        end else if (stop_i) begin
            run_d = 1'b0;
        end else if (run_q) begin
            if (cnt_q == '0) begin
                run_d = 1'b0;
                exp_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // ========================================================
    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            exp_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            exp_q <= exp_d;
        end
    end

    assign expired_o = exp_q;

endmodule
`default_nettype wire

//--- logic/fpe_ctrl.sv
// Purpose: flash program/erase sequencer with wishbone control registers
// Assumes: rst_i is the power-on reset; the array answers with done/fail
// Notes:   summary below; register map in the package
//
// Summary of operation
// - setting start launches the chosen operation; hardware clears start when done
// - start reads zero whenever no operation is running
// - software writes of zero to start are ignored
// - modify-permit zero blocks every program or erase launch
// - error flag sets on improper start attempt or failed termination
// - error flag clears on a clean start that writes it as zero and stays zero after success
// - erase select chooses erase or program meaning of the code
// - erase codes 1111 bulk, 0010 page, 0000 config byte; 0011/0001 idle
// - erase codes 1101 general segment, 1100 secure segment; others reserved
// - program codes 0011 word, 0001 row, 0000 config byte; rest idle
// - all control bits zero at power-on reset, the only reset that loads them
// - bits 12..7 and 5..4 read as zero
`timescale 1ns/1ps
`default_nettype none
module fpe_ctrl
    import fpe_pkg::*;
#(
    parameter int TMO_CYC = FPE_TMO_CYC,
    parameter int TW      = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // flash array side
    output logic             arr_go_o,
    output logic [2:0]       arr_kind_o,
    input  wire logic        arr_done_i,
    input  wire logic        arr_fail_i,
    // interrupt
    output logic             irq_o
);

    typedef enum logic [2:0] {
        FPE_S_IDLE = 3'b001,
        FPE_S_BUSY = 3'b010,
        FPE_S_NOP  = 3'b100
    } fpe_state_t;

    // ========================================================
    // decode op code against erase select
    function automatic fpe_kind_t op_kind(input logic erase,
                                          input logic [3:0] op);
        fpe_kind_t k;
        k = FPE_K_NONE;
        if (erase) begin
            case (op)
                FPE_OP_BULK:   k = FPE_K_BULK;
                FPE_OP_GENSEG: k = FPE_K_GENSEG;
                FPE_OP_SECSEG: k = FPE_K_SECSEG;
                FPE_OP_PAGE:   k = FPE_K_PAGE;
                FPE_OP_CFG:    k = FPE_K_CFG;
                default:       k = FPE_K_NONE;
            endcase
        end else begin
            case (op)
                FPE_OP_WORD: k = FPE_K_WORD;
                FPE_OP_ROW:  k = FPE_K_ROW;
                FPE_OP_CFG:  k = FPE_K_CFG;
                default:     k = FPE_K_NONE;
            endcase
        end
        return k;
    endfunction

    fpe_state_t st_q, st_d;
    logic       start_q, start_d;
    logic       permit_q, permit_d;
    logic       err_q, err_d;
    logic       erase_q, erase_d;
    logic [3:0] op_q, op_d;
    fpe_kind_t  kind_q, kind_d;
    logic       go_q, go_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic       ack_q, ack_d;
    logic       err_ack_q, err_ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic       tmr_load, tmr_stop, tmr_exp;
    logic [TW-1:0] tmr_cnt;

    logic        req, wr_ctrl, wr_hi, wr_lo, mapped;
    logic [15:0] ctrl_rd;
    logic        ev_done, ev_err;

    assign req     = wb_cyc_i && wb_stb_i && !ack_q && !err_ack_q;
    assign mapped  = (wb_adr_i == FPE_OFF_CTRL) ||
                     (wb_adr_i == FPE_OFF_STAT) ||
                     (wb_adr_i == FPE_OFF_MASK);
    assign wr_ctrl = req && wb_we_i && (wb_adr_i == FPE_OFF_CTRL);
    assign wr_hi   = wr_ctrl && wb_sel_i[1];
    assign wr_lo   = wr_ctrl && wb_sel_i[0];

    always_comb begin
        ctrl_rd = 16'h0000;
        ctrl_rd[FPE_BIT_START]  = start_q;
        ctrl_rd[FPE_BIT_PERMIT] = permit_q;
        ctrl_rd[FPE_BIT_ERR]    = err_q;
        ctrl_rd[FPE_BIT_ERASE]  = erase_q;
        ctrl_rd[FPE_OP_LSB +: 4] = op_q;
    end

    // ========================================================
    // sequencer and control register next state
    always_comb begin
        st_d     = st_q;
        start_d  = start_q;
        permit_d = permit_q;
        err_d    = err_q;
        erase_d  = erase_q;
        op_d     = op_q;
        kind_d   = kind_q;
        go_d     = 1'b0;
        ev_done  = 1'b0;
        ev_err   = 1'b0;
        tmr_load = 1'b0;
        tmr_stop = 1'b0;
        tmr_cnt  = TW'(TMO_CYC);
        // low byte fields are frozen while an operation runs
        if (wr_lo && st_q == FPE_S_IDLE) begin
            erase_d = wb_dat_i[FPE_BIT_ERASE];
            op_d    = wb_dat_i[FPE_OP_LSB +: 4];
        end
        if (wr_hi)
            permit_d = wb_dat_i[FPE_BIT_PERMIT];
        case (st_q)
            FPE_S_IDLE: begin
                // only a one on start acts
                if (wr_hi && wb_dat_i[FPE_BIT_START]) begin
                    if (!wb_dat_i[FPE_BIT_PERMIT] || !permit_q) begin
                        err_d  = 1'b1;
                        ev_err = 1'b1;
                    end else begin
                        start_d = 1'b1;
                        err_d   = wb_dat_i[FPE_BIT_ERR] & err_q;
                        kind_d  = op_kind(wr_lo ? wb_dat_i[FPE_BIT_ERASE]
                                                : erase_q,
                                          wr_lo ? wb_dat_i[3:0] : op_q);
                        tmr_load = 1'b1;
                        if (kind_d == FPE_K_NONE) begin
                            tmr_cnt = TW'(FPE_NOP_CYC);
                            st_d    = FPE_S_NOP;
                        end else begin
                            go_d = 1'b1;
                            st_d = FPE_S_BUSY;
                        end
                    end
                end
            end
            FPE_S_BUSY: begin
                // failure or timeout is improper termination
                if (arr_fail_i || tmr_exp) begin
                    err_d    = 1'b1;
                    ev_err   = 1'b1;
                    start_d  = 1'b0;
                    tmr_stop = 1'b1;
                    st_d     = FPE_S_IDLE;
                end else if (arr_done_i) begin
                    start_d  = 1'b0;
                    ev_done  = 1'b1;
                    tmr_stop = 1'b1;
                    st_d     = FPE_S_IDLE;
                end
            end
            FPE_S_NOP: begin
                if (tmr_exp) begin
                    start_d = 1'b0;
                    ev_done = 1'b1;
                    st_d    = FPE_S_IDLE;
                end
            end
            default: begin
                st_d    = FPE_S_IDLE;
                start_d = 1'b0;
            end
        endcase
    end

    // ========================================================
    // interrupt status (set wins over clear) and mask
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (req && wb_we_i && wb_adr_i == FPE_OFF_STAT && wb_sel_i[0])
            stat_d = stat_q & ~wb_dat_i[1:0];
        if (req && wb_we_i && wb_adr_i == FPE_OFF_MASK && wb_sel_i[0])
            mask_d = wb_dat_i[1:0];
        if (ev_done)
            stat_d[FPE_IRQ_DONE] = 1'b1;
        if (ev_err)
            stat_d[FPE_IRQ_ERR] = 1'b1;
    end

    // ========================================================
    // bus answer: one cycle after the request, err on unmapped
    always_comb begin
        ack_d     = req && mapped;
        err_ack_d = req && !mapped;
        rdat_d    = rdat_q;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                FPE_OFF_CTRL: rdat_d = {16'h0000, ctrl_rd};
                FPE_OFF_STAT: rdat_d = {30'h0000_0000, stat_q};
                FPE_OFF_MASK: rdat_d = {30'h0000_0000, mask_q};
                default:      rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // single reset is the power-on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q      <= FPE_S_IDLE;
            start_q   <= FPE_CTRL_RST[FPE_BIT_START];
            permit_q  <= FPE_CTRL_RST[FPE_BIT_PERMIT];
            err_q     <= FPE_CTRL_RST[FPE_BIT_ERR];
            erase_q   <= FPE_CTRL_RST[FPE_BIT_ERASE];
            op_q      <= FPE_CTRL_RST[3:0];
            kind_q    <= FPE_K_NONE;
            go_q      <= 1'b0;
            stat_q    <= 2'b00;
            mask_q    <= 2'b00;
            ack_q     <= 1'b0;
            err_ack_q <= 1'b0;
            rdat_q    <= 32'h0000_0000;
        end else begin
            st_q      <= st_d;
            start_q   <= start_d;
            permit_q  <= permit_d;
            err_q     <= err_d;
            erase_q   <= erase_d;
            op_q      <= op_d;
            kind_q    <= kind_d;
            go_q      <= go_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            ack_q     <= ack_d;
            err_ack_q <= err_ack_d;
            rdat_q    <= rdat_d;
        end
    end

    // operation timer, shared by real and empty operations
    fpe_timer #(
        .W (TW)
    ) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .load_i    (tmr_load),
        .count_i   (tmr_cnt),
        .stop_i    (tmr_stop),
        .expired_o (tmr_exp)
    );

    assign wb_dat_o   = rdat_q;
    assign wb_ack_o   = ack_q;
    assign wb_err_o   = err_ack_q;
    assign arr_go_o   = go_q;
    assign arr_kind_o = kind_q;
    assign irq_o      = |(stat_q & mask_q);

    // ========================================================
    // checks
    // start low only when idle
    a_start_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_q == (st_q != FPE_S_IDLE)))
        else $error("start bit disagrees with sequencer state");
    // zero write never clears a running start
    a_start_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_q && !arr_done_i && !arr_fail_i && !tmr_exp) |=> start_q)
        else $error("start bit dropped without completion");
    a_permit_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        go_q |-> $past(permit_q))
        else $error("array started without modify permit");
    a_fail_err: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == FPE_S_BUSY && arr_fail_i) |=> (err_q && !start_q))
        else $error("failure did not raise error flag");
    a_done_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == FPE_S_BUSY && arr_done_i && !arr_fail_i && !tmr_exp)
        |=> !start_q ##0 stat_q[FPE_IRQ_DONE])
        else $error("completion did not clear start");
    // empty op never touches array and ends in bounded time
    a_nop_end: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(st_q == FPE_S_NOP) |-> (!go_q) ##[1:8] !start_q)
        else $error("empty operation did not finish");
    // bulk code in erase mode issues bulk kind
    a_kind_bulk: assert property (@(posedge clk_i) disable iff (rst_i)
        (go_q && erase_q && op_q == FPE_OP_BULK) |-> kind_q == FPE_K_BULK)
        else $error("wrong kind for bulk erase");
    // row code in program mode issues row kind
    a_kind_row: assert property (@(posedge clk_i) disable iff (rst_i)
        (go_q && !erase_q && op_q == FPE_OP_ROW) |-> kind_q == FPE_K_ROW)
        else $error("wrong kind for row program");
    a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_q |-> (rdat_q[31:16] == 16'h0000))
        else $error("reserved bits not zero");

endmodule
`default_nettype wire

//--- verif/fpe_array_model.sv
// Purpose: behavioural flash array that answers launch pulses
// Assumes: one operation at a time; a new launch restarts its timer
// Notes:   latency and failure are steered by the testbench
`timescale 1ns/1ps
`default_nettype none
module fpe_array_model
    import fpe_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       go_i,
    input  wire logic [2:0] kind_i,
    input  wire logic [7:0] lat_i,
    input  wire logic       bad_i,
    output logic            done_o,
    output logic            fail_o
);
    logic       busy_q;
    logic [7:0] cnt_q;

    // ========================================================
    // array timing
    // answers lat_i+1 cycles after a launch, one-cycle done or fail
    // self timed, empty kind ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            cnt_q  <= 8'h00;
            done_o <= 1'b0;
            fail_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            fail_o <= 1'b0;
            if (go_i && kind_i != FPE_K_NONE) begin
                busy_q <= 1'b1;
                cnt_q  <= lat_i;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q <= 1'b0;
                done_o <= !bad_i;
                fail_o <= bad_i; // aborted operation
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Purpose: self-checking bench for the flash program/erase sequencer
// Assumes: classic wishbone master, one transfer at a time
// Notes:   short timeout parameter so a stuck array is quick to provoke
`timescale 1ns/1ps
`default_nettype none
module testbench
    import fpe_pkg::*;
;
    localparam int TMO = 60;
    logic        clk_i, rst_i, cyc, stb, we, bad, berr;
    logic        wb_ack_o, wb_err_o, arr_go_o, done, fail, irq_o;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, q, wb_dat_o, w;
    logic [7:0]  lat;
    logic [2:0]  arr_kind_o, go_kind, k;
    int          errors, tests_run, go_cnt, g;
    logic [3:0]  codes [9] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h3, 4'h2,
                               4'h1, 4'h0};
    logic [2:0]  ek [9] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h0, 3'h0, 3'h4,
                            3'h0, 3'h7};
    logic [2:0]  pk [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5, 3'h0,
                            3'h6, 3'h7};

    fpe_ctrl #(.TMO_CYC(TMO), .TW(16)) i_fpe_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .arr_go_o(arr_go_o), .arr_kind_o(arr_kind_o),
        .arr_done_i(done), .arr_fail_i(fail), .irq_o(irq_o));

    fpe_array_model i_fpe_array_model (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(arr_go_o),
        .kind_i(arr_kind_o), .lat_i(lat), .bad_i(bad),
        .done_o(done), .fail_o(fail));

    // ========================================================
    // clock, launch monitor, watchdog
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (arr_go_o === 1'b1) begin
            go_cnt  <= go_cnt + 1;
            go_kind <= arr_kind_o;
        end
    end
    // far longer than the whole sequence needs
    initial begin
        repeat (8000) @(posedge clk_i);
        errors++;
        print_verdict();
    end

    // ========================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask
    // request held until ack or err is sampled high, then released
    task automatic wb(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= wr;
        adr  <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        berr = wb_err_o;
        if (n >= 50) chk(32'h1, 32'h0, "no bus answer");
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // polls control until start reads zero
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, FPE_OFF_CTRL, 32'h0);
            n++;
        end while (q[15] !== 1'b0 && n < 100);
        chk(q[15], 32'h0, "start never cleared");
    endtask
    task automatic print_verdict();
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'hF;
        wdat = 32'h0;
        lat = 8'h1E;
        bad = 1'b0;
        errors = 0;
        tests_run = 0;
        go_cnt = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, FPE_OFF_CTRL, 32'h0);
        chk(q, 32'h0, "control power-on value");
        wb(1'b0, 4'hC, 32'h0);
        chk(berr, 32'h1, "unmapped address");
        // start without modify permit is refused and flagged
        g = go_cnt;
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_804F);
        wb(1'b0, FPE_OFF_CTRL, 32'h0);
        chk(q[15:13], 32'h1, "refused start");
        chk(go_cnt - g, 32'h0, "blocked launch");
        wb(1'b1, FPE_OFF_MASK, 32'h3);
        wb(1'b1, FPE_OFF_STAT, 32'h3);
        wb(1'b0, FPE_OFF_STAT, 32'h0);
        chk(irq_o, 32'h0, "irq after clear");
        // slow bulk erase; zero written to start while busy
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_4000);
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_C04F);
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_4000);
        wb(1'b0, FPE_OFF_CTRL, 32'h0);
        chk(q[15], 32'h1, "start while busy");
        chk(go_kind, 32'h1, "bulk erase kind");
        wait_idle();
        chk(q[15:13], 32'h2, "clean finish");
        wb(1'b0, FPE_OFF_STAT, 32'h0);
        chk(q[0], 32'h1, "done status");
        chk(irq_o, 32'h1, "irq raised");
        wb(1'b1, FPE_OFF_MASK, 32'h2);
        wb(1'b0, FPE_OFF_STAT, 32'h0);
        chk(irq_o, 32'h0, "irq masked");
        wb(1'b1, FPE_OFF_MASK, 32'h3);
        wb(1'b1, FPE_OFF_STAT, 32'h1);
        wb(1'b0, FPE_OFF_STAT, 32'h0);
        chk(irq_o, 32'h0, "irq cleared");
        // every listed code in both modes, prompt array
        lat <= 8'h03;
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 9; i++) begin
                k = m[0] ? ek[i] : pk[i];
                g = go_cnt;
                w = {16'h0000, 2'h3, 7'h00, m[0], 2'h0, codes[i]};
                wb(1'b1, FPE_OFF_CTRL, w);
                wait_idle();
                chk(q[13], 32'h0, "error after op");
                chk(go_cnt - g, k != 3'h0, "launch count");
                if (k != 3'h0) chk(go_kind, k, "kind");
            end
        end
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_5FB0);
        wb(1'b0, FPE_OFF_CTRL, 32'h0);
        chk(q & 32'h0000_1FB0, 32'h0, "unused bits");
        // array abort, then internal timeout
        bad <= 1'b1;
        wb(1'b1, FPE_OFF_STAT, 32'h3);
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_C042);
        wait_idle();
        chk(q[13], 32'h1, "abort sets error");
        wb(1'b0, FPE_OFF_STAT, 32'h0);
        chk(q[1], 32'h1, "error status");
        bad <= 1'b0;
        lat <= 8'h64;
        wb(1'b1, FPE_OFF_CTRL, 32'h0000_C042);
        wait_idle();
        chk(q[13], 32'h1, "timeout sets error");
        // second power-on reset once the sequencer is idle again
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, FPE_OFF_CTRL, 32'h0);
        chk(q, 32'h0, "control after reset");
        print_verdict();
    end
endmodule
`default_nettype wire
